// >>> rtl/apcl_pkg.sv
// Purpose: shared constants for the absolute position compare/latch block
// Assumes: 125 MHz system clock
// Notes: register offsets are word addresses on the plain register port
`default_nettype none
package apcl_pkg;
  localparam int unsigned APCL_POS_W = 31;
  localparam logic [3:0] APCL_ADDR_CFG = 4'h0;
  localparam logic [3:0] APCL_ADDR_STEPS = 4'h1;
  localparam logic [3:0] APCL_ADDR_REF = 4'h2;
  localparam logic [3:0] APCL_ADDR_CTRL = 4'h3;
  localparam logic [3:0] APCL_ADDR_STAT = 4'h4;
  localparam logic [3:0] APCL_ADDR_FEED = 4'h5;
  localparam logic [3:0] APCL_ADDR_REF1 = 4'h6;
  localparam logic [3:0] APCL_ADDR_REF2 = 4'h7;
  // cfg fields
  localparam int unsigned APCL_CFG_TRAIL_LSB = 0;
  localparam int unsigned APCL_CFG_FRAME_LSB = 4;
  localparam int unsigned APCL_CFG_NORM = 8;
  localparam int unsigned APCL_CFG_REV = 9;
  localparam int unsigned APCL_CFG_CMP1_LSB = 10;
  localparam int unsigned APCL_CFG_CMP2_LSB = 12;
  localparam int unsigned APCL_CFG_LEDGE_LSB = 14;
  localparam int unsigned APCL_CFG_LEN = 16;
  localparam int unsigned APCL_CFG_FAST = 17;
  localparam int unsigned APCL_CFG_ISO = 18;
  // ctrl fields
  localparam int unsigned APCL_CTRL_LD1 = 0;
  localparam int unsigned APCL_CTRL_LD2 = 1;
  localparam int unsigned APCL_CTRL_ACK = 2;
  localparam logic [31:0] APCL_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] APCL_STEPS_RST = 32'h0000_2000;
  // frame length in bits for each frame type code
  localparam logic [4:0] APCL_FRAME_13 = 5'hd;
  localparam logic [4:0] APCL_FRAME_14 = 5'he;
  localparam logic [4:0] APCL_FRAME_16 = 5'h10;
  localparam logic [4:0] APCL_FRAME_21 = 5'h15;
  localparam logic [4:0] APCL_FRAME_24 = 5'h18;
  localparam logic [4:0] APCL_FRAME_25 = 5'h19;
  typedef enum logic [1:0] {APCL_CMP_OFF, APCL_CMP_UP, APCL_CMP_DOWN, APCL_CMP_BOTH} apcl_cmp_mode_type;
  typedef enum logic [1:0] {APCL_EDGE_NONE, APCL_EDGE_RISE, APCL_EDGE_FALL, APCL_EDGE_ANY} apcl_edge_type;
endpackage : apcl_pkg
`default_nettype wire

// >>> rtl/apcl_top.sv
// Purpose: direction, reversal, two comparators and an edge latch on an absolute position
// Assumes: frame word and update/instant strobes are synchronous to sys_clk_i
// Notes: one update per upd_stb_i; isochrone instants come from the bus-cycle logic
//
// Overview of operation
// R1 - extract position using frame type, steps, trailing bits
// R2 - report up and down movement on outputs
// R3 - reversal off passes position unchanged
// R4 - reversal on mirrors position within step range
// R5 - two comparators against loadable references
// R6 - comparator inactive until reference loaded once
// R7 - not-active mode holds result flag zero
// R8 - up mode: on up movement set at-or-above, clear below; hold otherwise
// R9 - down mode: on down movement set at-or-below, clear above; hold otherwise
// R10 - both mode: test per direction, hold still
// R11 - reference load clears flag then re-evaluates
// R12 - both load bits set raises load error
// R13 - isochrone: take at output, apply at input
// R14 - compare and latch absent in fast mode
// R15 - latch freezes position on configured edge
// R16 - frozen value replaces position with marker bit
// R17 - live evaluation continues while frozen
// R18 - acknowledge clears marker and re-arms latch
// R19 - normalization drops trailing bits
// R20 - evaluation uses normalized reversed position per update
`default_nettype none
module apcl_top
  import apcl_pkg::*;
#(
  parameter int unsigned FRAME_W = 25
)(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // encoder value path
  input wire logic [FRAME_W-1:0] frame_i,
  input wire logic upd_stb_i,
  input wire logic iso_out_stb_i,
  input wire logic iso_in_stb_i,
  input wire logic latch_trigger_input_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // indicators
  output logic up_movement_indicator_o,
  output logic down_movement_indicator_o,
  output logic [31:0] feedback_o,
  output logic compare_result_flag1_o,
  output logic compare_result_flag2_o,
  output logic load_error_o
);

  logic [31:0] cfg_q;
  logic [31:0] steps_q;
  logic [31:0] ref_stage_q;
  logic [2:0] ctrl_q;
  logic [APCL_POS_W-1:0] pos_q;
  logic pos_valid_q;
  logic up_q;
  logic dn_q;
  logic [31:0] ref1_q;
  logic [31:0] ref2_q;
  logic loaded1_q;
  logic loaded2_q;
  logic flag1_q;
  logic flag2_q;
  logic pend1_q;
  logic pend2_q;
  logic [31:0] iso_ref_q;
  logic iso_ld1_q;
  logic iso_ld2_q;
  logic trig_q;
  logic frozen_q;
  logic [APCL_POS_W-1:0] frz_q;
  logic [31:0] rdata_q;

  // configuration field decode
  wire [3:0] trail_w = cfg_q[APCL_CFG_TRAIL_LSB +: 4];
  wire [2:0] ftype_w = cfg_q[APCL_CFG_FRAME_LSB +: 3];
  wire norm_w = cfg_q[APCL_CFG_NORM];
  wire rev_w = cfg_q[APCL_CFG_REV];
  wire apcl_cmp_mode_type mode1_w = apcl_cmp_mode_type'(cfg_q[APCL_CFG_CMP1_LSB +: 2]);
  wire apcl_cmp_mode_type mode2_w = apcl_cmp_mode_type'(cfg_q[APCL_CFG_CMP2_LSB +: 2]);
  wire apcl_edge_type edge_w = apcl_edge_type'(cfg_q[APCL_CFG_LEDGE_LSB +: 2]);
  wire latch_en_w = cfg_q[APCL_CFG_LEN];
  wire fast_w = cfg_q[APCL_CFG_FAST];
  wire iso_w = cfg_q[APCL_CFG_ISO];

  // frame length picks how many received bits belong to the encoder
  logic [4:0] flen_w;
  always_comb
  begin
    unique case (ftype_w)
      3'h1: flen_w = APCL_FRAME_14;
      3'h2: flen_w = APCL_FRAME_16;
      3'h3: flen_w = APCL_FRAME_21;
      3'h4: flen_w = APCL_FRAME_24;
      3'h5: flen_w = APCL_FRAME_25;
      default: flen_w = APCL_FRAME_13;
    endcase
  end

  // extraction: mask frame length; with normalization on, drop trailing bits and mask to step range
  // steps must be a power of two for the mask; a non power leaves modulo to software
  wire [31:0] fmask_w = (32'h1 << flen_w) - 32'h1;
  wire [31:0] framed_w = 32'(frame_i) & fmask_w; // R1
  wire [31:0] shifted_w = norm_w ? (framed_w >> trail_w) : framed_w; // R19
  wire [31:0] smask_w = steps_q - 32'h1;
  wire [31:0] raw_w = norm_w ? (shifted_w & smask_w) : shifted_w; // R1
  // mirror inside the step range: 0 maps to steps-1
  wire [31:0] disp_w = rev_w ? (smask_w - raw_w) : raw_w; // R3 R4
  wire [APCL_POS_W-1:0] new_pos_w = disp_w[APCL_POS_W-1:0]; // R20

  // movement decode on the update strobe
  wire moved_up_w = upd_stb_i && pos_valid_q && (new_pos_w > pos_q); // R2
  wire moved_dn_w = upd_stb_i && pos_valid_q && (new_pos_w < pos_q); // R2

  // register port decode
  wire wr_cfg_w = wr_i && (addr_i == APCL_ADDR_CFG);
  wire wr_steps_w = wr_i && (addr_i == APCL_ADDR_STEPS);
  wire wr_ref_w = wr_i && (addr_i == APCL_ADDR_REF);
  wire wr_ctrl_w = wr_i && (addr_i == APCL_ADDR_CTRL);
  wire ld1_bit_w = ctrl_q[APCL_CTRL_LD1];
  wire ld2_bit_w = ctrl_q[APCL_CTRL_LD2];
  wire ack_bit_w = ctrl_q[APCL_CTRL_ACK];
  wire both_ld_w = ld1_bit_w && ld2_bit_w; // R12
  // a load is the rising of its control bit; isochrone loads wait for the input instant
  logic ld1_prev_q;
  logic ld2_prev_q;
  logic ack_prev_q;
  logic ld1_out_q, ld2_out_q, err_q;
  wire ld1_req_w = ld1_bit_w && !ld1_prev_q && !load_error_o && !fast_w; // R12
  wire ld2_req_w = ld2_bit_w && !ld2_prev_q && !load_error_o && !fast_w; // R12
  wire iso_new1_w = ld1_bit_w && !ld1_out_q && !load_error_o && !fast_w; // R13
  wire iso_new2_w = ld2_bit_w && !ld2_out_q && !load_error_o && !fast_w; // R13
  wire take1_w = iso_w ? (iso_ld1_q && iso_in_stb_i) : ld1_req_w; // R13
  wire take2_w = iso_w ? (iso_ld2_q && iso_in_stb_i) : ld2_req_w; // R13
  wire [31:0] take_val_w = iso_w ? iso_ref_q : ref_stage_q;
  wire ack_rise_w = ack_bit_w && !ack_prev_q;

  // software registers
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cfg_q <= APCL_CFG_RST;
      steps_q <= APCL_STEPS_RST;
      ref_stage_q <= 32'h0;
      ctrl_q <= 3'h0;
    end
    else
    begin
      if (wr_cfg_w) cfg_q <= wdata_i;
      if (wr_steps_w) steps_q <= wdata_i;
      if (wr_ref_w) ref_stage_q <= wdata_i;
      if (wr_ctrl_w) ctrl_q <= wdata_i[2:0];
    end
  end

  // control bit edge history
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ld1_prev_q <= 1'b0;
      ld2_prev_q <= 1'b0;
      ack_prev_q <= 1'b0;
      err_q <= 1'b0;
    end
    else
    begin
      ld1_prev_q <= ld1_bit_w;
      ld2_prev_q <= ld2_bit_w;
      ack_prev_q <= ack_bit_w;
      err_q <= load_error_o; // R12
    end
  end

  // isochrone staging: control bits are judged only at output instants, so a load written
  // between two instants is not lost; the value is held until the input instant
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      iso_ref_q <= 32'h0;
      iso_ld1_q <= 1'b0;
      iso_ld2_q <= 1'b0;
      ld1_out_q <= 1'b0;
      ld2_out_q <= 1'b0;
    end
    else if (iso_out_stb_i)
    begin
      ld1_out_q <= ld1_bit_w;
      ld2_out_q <= ld2_bit_w;
      if (iso_new1_w || iso_new2_w) iso_ref_q <= ref_stage_q; // R13
      iso_ld1_q <= iso_ld1_q || iso_new1_w;
      iso_ld2_q <= iso_ld2_q || iso_new2_w;
    end
    else if (iso_in_stb_i)
    begin
      iso_ld1_q <= 1'b0;
      iso_ld2_q <= 1'b0;
    end
  end

  // live position and direction; runs regardless of the latch
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pos_q <= '0;
      pos_valid_q <= 1'b0;
      up_q <= 1'b0;
      dn_q <= 1'b0;
    end
    else if (upd_stb_i)
    begin
      pos_q <= new_pos_w; // R17
      pos_valid_q <= 1'b1;
      if (moved_up_w || moved_dn_w)
      begin
        up_q <= moved_up_w; // R2
        dn_q <= moved_dn_w; // R2
      end
    end
  end

  // next flag value for one comparator against the live update
  function automatic logic cmp_next(input apcl_cmp_mode_type mode, input logic flag,
                                    input logic [31:0] refv, input logic up, input logic dn,
                                    input logic [APCL_POS_W-1:0] pos);
    logic r;
    r = flag;
    unique case (mode)
      APCL_CMP_OFF: r = 1'b0; // R7
      APCL_CMP_UP: if (up) r = (32'(pos) >= refv); // R8
      APCL_CMP_DOWN: if (dn) r = (32'(pos) <= refv); // R9
      APCL_CMP_BOTH:
      begin
        if (up) r = (32'(pos) >= refv); // R10
        else if (dn) r = (32'(pos) <= refv); // R10
      end
    endcase
    return r;
  endfunction

  // comparators: a load clears the flag, the next update re-evaluates it
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ref1_q <= 32'h0;
      ref2_q <= 32'h0;
      loaded1_q <= 1'b0;
      loaded2_q <= 1'b0;
      flag1_q <= 1'b0;
      flag2_q <= 1'b0;
      pend1_q <= 1'b0;
      pend2_q <= 1'b0;
    end
    else if (fast_w)
    begin
      loaded1_q <= 1'b0; // R14
      loaded2_q <= 1'b0;
      flag1_q <= 1'b0;
      flag2_q <= 1'b0;
      pend1_q <= 1'b0;
      pend2_q <= 1'b0;
    end
    else
    begin
      if (take1_w)
      begin
        ref1_q <= take_val_w;
        loaded1_q <= 1'b1; // R6
        flag1_q <= 1'b0; // R11
        pend1_q <= 1'b1;
      end
      else if (!loaded1_q || mode1_w == APCL_CMP_OFF)
        flag1_q <= 1'b0; // R6 R7
      else if (upd_stb_i)
      begin
        // a pending reload is settled against the current position by direction setting
        flag1_q <= pend1_q ? cmp_next(mode1_w, 1'b0, ref1_q, mode1_w != APCL_CMP_DOWN && (moved_up_w ||
                   !moved_dn_w), moved_dn_w || mode1_w == APCL_CMP_DOWN, new_pos_w) // R11
                   : cmp_next(mode1_w, flag1_q, ref1_q, moved_up_w, moved_dn_w, new_pos_w); // R5
        pend1_q <= 1'b0;
      end
      if (take2_w)
      begin
        ref2_q <= take_val_w;
        loaded2_q <= 1'b1; // R6
        flag2_q <= 1'b0; // R11
        pend2_q <= 1'b1;
      end
      else if (!loaded2_q || mode2_w == APCL_CMP_OFF)
        flag2_q <= 1'b0; // R6 R7
      else if (upd_stb_i)
      begin
        flag2_q <= pend2_q ? cmp_next(mode2_w, 1'b0, ref2_q, mode2_w != APCL_CMP_DOWN && (moved_up_w ||
                   !moved_dn_w), moved_dn_w || mode2_w == APCL_CMP_DOWN, new_pos_w) // R11
                   : cmp_next(mode2_w, flag2_q, ref2_q, moved_up_w, moved_dn_w, new_pos_w); // R5
        pend2_q <= 1'b0;
      end
    end
  end

  // latch trigger edge detect; input taken as synchronous
  wire rise_w = latch_trigger_input_i && !trig_q;
  wire fall_w = !latch_trigger_input_i && trig_q;
  wire edge_hit_w = (edge_w == APCL_EDGE_RISE && rise_w) || (edge_w == APCL_EDGE_FALL && fall_w) ||
                    (edge_w == APCL_EDGE_ANY && (rise_w || fall_w)); // R15
  wire freeze_w = latch_en_w && !fast_w && !frozen_q && edge_hit_w; // R14 R15

  // latch: holds the frozen value until acknowledged, then re-arms
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      trig_q <= 1'b0;
      frozen_q <= 1'b0;
      frz_q <= '0;
    end
    else
    begin
      trig_q <= latch_trigger_input_i;
      if (freeze_w)
      begin
        frozen_q <= 1'b1; // R15
        frz_q <= pos_q;
      end
      else if (ack_rise_w || fast_w)
        frozen_q <= 1'b0; // R18
    end
  end

  // feedback word: frozen value with marker bit replaces live position
  wire [31:0] feed_w = frozen_q ? {1'b1, frz_q} : {1'b0, pos_q}; // R16
  wire [31:0] stat_w = {26'h0, load_error_o, flag2_q, flag1_q, frozen_q, dn_q, up_q};

  // read mux; unmapped offsets read zero
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rdata_q <= 32'h0;
    else if (rd_i)
    begin
      unique case (addr_i)
        APCL_ADDR_CFG: rdata_q <= cfg_q;
        APCL_ADDR_STEPS: rdata_q <= steps_q;
        APCL_ADDR_REF: rdata_q <= ref_stage_q;
        APCL_ADDR_CTRL: rdata_q <= {29'h0, ctrl_q};
        APCL_ADDR_STAT: rdata_q <= stat_w;
        APCL_ADDR_FEED: rdata_q <= feed_w;
        APCL_ADDR_REF1: rdata_q <= ref1_q;
        APCL_ADDR_REF2: rdata_q <= ref2_q;
        default: rdata_q <= 32'h0;
      endcase
    end
    else
      rdata_q <= 32'h0;
  end

  assign rdata_o = rdata_q;
  assign up_movement_indicator_o = up_q;
  assign down_movement_indicator_o = dn_q;
  assign feedback_o = feed_w;
  assign compare_result_flag1_o = flag1_q;
  assign compare_result_flag2_o = flag2_q;
  assign load_error_o = both_ld_w || (err_q && (ld1_bit_w || ld2_bit_w)); // R12

  // checks
  a_load_error_both: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    load_error_o && !iso_w |=> $stable(ref1_q) && $stable(ref2_q)) else $error("load taken during load error"); // R12
  a_off_flag_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (mode1_w == APCL_CMP_OFF) |=> !flag1_q || take1_w) else $error("off comparator flag set"); // R7
  a_unloaded_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    !loaded2_q |-> !flag2_q) else $error("unloaded comparator active"); // R6
  a_load_clears: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    take1_w |=> !flag1_q) else $error("load did not clear flag"); // R11
  a_marker_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    frozen_q && !ack_rise_w && !fast_w |=> feedback_o[31] && $stable(frz_q)) else $error("frozen value lost"); // R16
  a_ack_rearm: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    frozen_q && ack_rise_w |=> !feedback_o[31]) else $error("ack did not clear marker"); // R18
  a_freeze_edge: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    freeze_w |=> feedback_o[31] && feedback_o[30:0] == $past(pos_q)) else $error("freeze value wrong"); // R15
  a_fast_absent: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    fast_w |=> !flag1_q && !flag2_q && !frozen_q) else $error("fast mode has compare or latch"); // R14
  a_up_dir: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    moved_up_w |=> up_movement_indicator_o && !down_movement_indicator_o) else $error("up not shown"); // R2
  a_live_track: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    upd_stb_i |=> pos_q == $past(new_pos_w)) else $error("live position stalled"); // R17

endmodule // apcl_top
`default_nettype wire

// >>> sim/apcl_enc_model.sv
// Purpose: encoder frame source at the far side of the position path
// Assumes: 13-bit frame right aligned, position above the trailing bits
// Notes: between updates the frame lines toggle, so only the strobe may sample them
`default_nettype none
module apcl_enc_model
  import apcl_pkg::*;
#(
  parameter int unsigned FRAME_W = 25
)(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // request from the bench
  input wire logic req_i,
  input wire logic [15:0] pos_i,
  input wire logic [3:0] trail_i,
  // frame path into the block
  output logic [FRAME_W-1:0] frame_o,
  output logic upd_stb_o
);
  // one frame per request; trailing bits carry noise the block has to drop
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      frame_o <= '0;
      upd_stb_o <= 1'b0;
    end
    else if (req_i)
    begin
      frame_o <= (FRAME_W'(pos_i) << trail_i) | (FRAME_W'($urandom) & ((FRAME_W'(1) << trail_i) - FRAME_W'(1)));
      upd_stb_o <= 1'b1;
    end
    else
    begin
      frame_o <= ~frame_o; // stale data never looks valid
      upd_stb_o <= 1'b0;
    end
  end
endmodule // apcl_enc_model
`default_nettype wire

// >>> sim/tb.sv
// Purpose: self-checking bench for the position compare and latch block
// Assumes: 13-bit frames, 3 trailing bits, 1024 steps
// Notes: every result is read back over the register port and scored from a queue
`default_nettype none
module tb
  import apcl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i, rst_b_i, req, trig, iso_o, iso_n, wr_i, rd_i, rd_d1, stb;
  logic up_o, dn_o, f1_o, f2_o, lerr_o;
  logic [3:0] addr_i;
  logic [31:0] wdata_i, rdata_o, feedback_o, ex_s;
  string nm_s;
  logic [24:0] frame;
  logic [15:0] pos, live;
  logic [31:0] exp_q[$];
  string nm_q[$];
  int fail_count, n_compared;

  apcl_enc_model u_enc (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .req_i(req), .pos_i(pos),
    .trail_i(4'h3), .frame_o(frame), .upd_stb_o(stb));
  apcl_top u_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .frame_i(frame), .upd_stb_i(stb),
    .iso_out_stb_i(iso_o), .iso_in_stb_i(iso_n), .latch_trigger_input_i(trig), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .up_movement_indicator_o(up_o),
    .down_movement_indicator_o(dn_o), .feedback_o(feedback_o), .compare_result_flag1_o(f1_o),
    .compare_result_flag2_o(f2_o), .load_error_o(lerr_o));

  // clock, 8 ns period
  initial
  begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_compared++;
    if (seen !== ex)
    begin
      $display("MISMATCH %s exp %h seen %h", nm, ex, seen);
      fail_count++;
    end
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // read data stand only in the cycle after the strobe, so score exactly there
  always @(posedge sys_clk_i)
  begin
    if (rd_d1)
    begin
      nm_s = nm_q.pop_front();
      ex_s = exp_q.pop_front();
      check(nm_s, rdata_o, ex_s);
      // the pins must agree with the register view in the same cycle
      if (nm_s == "stat")
        check("pins", 32'({lerr_o, f2_o, f1_o, feedback_o[31], dn_o, up_o}), ex_s);
      if (nm_s == "feed")
        check("feedback", feedback_o, ex_s);
    end
    rd_d1 <= rd_i;
  end

  // cut a hang short
  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    check("watchdog", 32'h0, 32'h1);
    test_done();
  end

  // gap cycle after each strobe keeps one assignment per signal per time step
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic st(input logic [5:0] s);
    rd(APCL_ADDR_STAT, 32'(s), "stat");
  endtask

  // one update with a new encoder position
  task automatic step(input logic [15:0] p);
    pos <= p;
    req <= 1'b1;
    @(posedge sys_clk_i);
    req <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    live = p;
  endtask

  task automatic ld(input logic [31:0] n, input logic [31:0] v);
    wr(APCL_ADDR_REF, v);
    wr(APCL_ADDR_CTRL, n);
    wr(APCL_ADDR_CTRL, 32'h0);
  endtask

  // fl is {isochrone, fast, latch enable, reverse}; 13-bit frame, 3 trailing, normalized
  function automatic logic [31:0] cfg(input logic [1:0] c1, c2, e, input logic [3:0] fl);
    cfg = 32'h0000_0103 | (32'(c1) << APCL_CFG_CMP1_LSB) | (32'(c2) << APCL_CFG_CMP2_LSB)
      | (32'(e) << APCL_CFG_LEDGE_LSB) | (32'(fl[0]) << APCL_CFG_REV) | (32'(fl[3:1]) << APCL_CFG_LEN);
  endfunction

  // edge on the trigger, one live update, then acknowledge
  task automatic latch_try(input logic lvl, input logic hit, input logic [15:0] p);
    logic [31:0] held;
    held = hit ? {1'b1, 31'(live)} : 32'(p);
    trig <= lvl;
    repeat (2) @(posedge sys_clk_i);
    step(p);
    rd(APCL_ADDR_FEED, held, "feed");
    st({3'h0, hit, 2'h1});
    wr(APCL_ADDR_CTRL, 32'h4);
    wr(APCL_ADDR_CTRL, 32'h0);
    rd(APCL_ADDR_FEED, 32'(p), "feed");
  endtask

  initial
  begin
    logic [15:0] p, r;
    logic f, u, d;
    {rst_b_i, req, trig, iso_o, iso_n, wr_i, rd_i} = 7'h00;
    addr_i = 4'h0;
    wdata_i = 32'h0;
    pos = 16'h0;
    live = 16'h0;
    void'($urandom(20498));
    repeat (12) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    @(posedge sys_clk_i);
    rd(APCL_ADDR_CFG, APCL_CFG_RST, "cfg");
    rd(APCL_ADDR_STEPS, APCL_STEPS_RST, "steps");
    wr(4'h9, 32'hffff_ffff);
    rd(4'h9, 32'h0, "unmapped");
    $display("test reset done");
    wr(APCL_ADDR_STEPS, 32'h0000_0400);
    wr(APCL_ADDR_CFG, cfg(APCL_CMP_UP, APCL_CMP_DOWN, APCL_EDGE_NONE, 4'h2));
    step(16'h0064);
    step(16'h00c8);
    rd(APCL_ADDR_FEED, 32'h0000_00c8, "feed");
    st(6'h01);
    ld(32'h1, 32'h0000_0096);
    rd(APCL_ADDR_REF1, 32'h0000_0096, "ref1");
    ld(32'h2, 32'h0000_0078);
    // walk 300, 100, 100, 140, 130 against references 150 and 120
    step(16'h012c);
    st(6'h09);
    step(16'h0064);
    st(6'h1a);
    step(16'h0064);
    st(6'h1a);
    step(16'h008c);
    st(6'h11);
    step(16'h0082);
    st(6'h02);
    step(16'h00a0);
    ld(32'h1, 32'h0000_009b);
    st(6'h01);
    step(16'h00aa);
    wr(APCL_ADDR_CTRL, 32'h3);
    st(6'h29);
    wr(APCL_ADDR_CTRL, 32'h1);
    st(6'h29);
    wr(APCL_ADDR_CTRL, 32'h0);
    st(6'h09);
    $display("test compare done");
    wr(APCL_ADDR_CFG, cfg(APCL_CMP_BOTH, APCL_CMP_OFF, APCL_EDGE_NONE, 4'h2));
    r = 16'($urandom_range(1023));
    ld(32'h1, 32'(r));
    {f, d, u} = 3'h1;
    for (int i = 0; i < 12; i++)
    begin
      p = (i % 4 == 3) ? live : 16'($urandom_range(1023));
      if (p != live)
        {d, u} = {p < live, p > live};
      if (p > live)
        f = p >= r;
      if (p < live)
        f = p <= r;
      if (i == 0 && p == live)
        f = p >= r;
      step(p);
      st({2'h0, f, 1'b0, d, u});
    end
    $display("test both directions done");
    wr(APCL_ADDR_CFG, cfg(APCL_CMP_OFF, APCL_CMP_OFF, APCL_EDGE_NONE, 4'h3));
    step(16'h03e8);
    step(16'h03ff);
    rd(APCL_ADDR_FEED, 32'h0, "feed");
    st(6'h02);
    $display("test reversal done");
    wr(APCL_ADDR_CFG, cfg(APCL_CMP_OFF, APCL_CMP_OFF, APCL_EDGE_NONE, 4'h2));
    step(16'h00c8);
    for (int e = 1; e < 4; e++)
    begin
      wr(APCL_ADDR_CFG, cfg(APCL_CMP_OFF, APCL_CMP_OFF, 2'(e), 4'h2));
      latch_try(1'b1, e != 2, 16'(200 + 80 * e));
      latch_try(1'b0, e != 1, 16'(240 + 80 * e));
    end
    $display("test latch done");
    // old reference stays in force until the input instant
    wr(APCL_ADDR_CFG, cfg(APCL_CMP_UP, APCL_CMP_OFF, APCL_EDGE_NONE, 4'h2));
    ld(32'h1, 32'h0000_0096);
    step(16'h0064);
    wr(APCL_ADDR_CFG, cfg(APCL_CMP_UP, APCL_CMP_OFF, APCL_EDGE_NONE, 4'ha));
    wr(APCL_ADDR_REF, 32'h0000_0384);
    wr(APCL_ADDR_CTRL, 32'h1);
    step(16'h01f4);
    st(6'h09);
    iso_o <= 1'b1;
    @(posedge sys_clk_i);
    iso_o <= 1'b0;
    iso_n <= 1'b1;
    @(posedge sys_clk_i);
    iso_n <= 1'b0;
    wr(APCL_ADDR_CTRL, 32'h0);
    step(16'h0258);
    st(6'h01);
    $display("test isochrone done");
    wr(APCL_ADDR_CFG, cfg(APCL_CMP_UP, APCL_CMP_OFF, APCL_EDGE_ANY, 4'h6));
    ld(32'h1, 32'h0000_000a);
    step(16'h03b6);
    st(6'h01);
    latch_try(1'b1, 1'b0, 16'h03d4);
    $display("test fast done");
    repeat (3) @(posedge sys_clk_i);
    check("queue", 32'(exp_q.size()), 32'h0);
    test_done();
  end
endmodule // tb
`default_nettype wire
